// file: core/wict_consts.svh
`ifndef WICT_CONSTS_SVH
`define WICT_CONSTS_SVH
// Register addresses (7-bit register address space)
`define WICT_ADDR_PULL      7'h08
`define WICT_ADDR_FILTER    7'h09
`define WICT_ADDR_TIMER     7'h0C
// Reset value of all three registers
`define WICT_RESET_VAL      8'h00
// Writable bit masks; reserved bits are excluded
`define WICT_MASK_CFG       8'h3F
`define WICT_MASK_TIMER     8'h77
// Field positions
`define WICT_ON_MSB         6
`define WICT_ON_LSB         4
`define WICT_PER_MSB        2
`define WICT_PER_LSB        0
// Clock rate and timing
`define WICT_CLK_KHZ        25000
`define WICT_FLT_SHORT_US   16
`define WICT_FLT_LONG_US    64
`define WICT_FLT_SHORT_CYC  ((`WICT_FLT_SHORT_US * `WICT_CLK_KHZ + 999) / 1000)
`define WICT_FLT_LONG_CYC   ((`WICT_FLT_LONG_US * `WICT_CLK_KHZ + 999) / 1000)
// One timer tick every 0.1 ms
`define WICT_TICK_US        100
`define WICT_TICK_CYC       ((`WICT_TICK_US * `WICT_CLK_KHZ) / 1000)
`endif

// file: core/wict_core.sv
// Behaviour
// RQ1: Reserved bits in the three registers read zero, writes ignored.
// RQ2: Third input pull field 5:4: none, down, up, automatic.
// RQ3: Second and first input pull fields at 3:2 and 1:0, same codes.
// RQ4: Reset loads zero into pull, filter and timer registers.
// RQ5: Static filter codes give 16 us or 64 us filtering.
// RQ6: Cyclic codes sample with 16 us filter at on-time end, timer one or two.
// RQ7: Filter fields for inputs c, b, a at 5:4, 3:2, 1:0.
// RQ8: Host routes the chosen timer to a high-side switch for cyclic sensing.
// RQ9: On-time codes 0.1, 0.3, 1, 10, 20 ms; 111 reserved.
// RQ10: On-time 000 stops timer low; 110 stops timer high.
// RQ11: Period codes 10 ms to 2 s; 111 reserved.
// RQ12: Timer starts by itself once a running on-time code is written.
// RQ13: Switches cleared in restart mode with cyclic sense clear timer fields.
// RQ14: Cyclic wake and cyclic sensing run together on the same timer.
// RQ15: Wake-enable bit makes timer one a cyclic wake source.
// RQ16: Switch mode 010 makes a switch follow timer one.
// RQ17: Reserved timer codes act as stopped timer with output low.
// RQ18: Cyclic sensing qualifies only a level stable for the window ending with on-time.
`timescale 1ns/1ps
`default_nettype none
`include "wict_consts.svh"
module wict_core
(
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   nrst,
	// Register access port
	input  wire wict_pkg::wict_reg_req_t req,
	output logic [7:0]                  rdata_q,
	// Context from the rest of the device
	input  wire logic                   timer_one_wake_enable,
	input  wire logic [2:0]             high_side_switch_mode,
	input  wire logic                   restart_mode,
	input  wire logic                   switches_cleared,
	input  wire logic                   t2_on,
	input  wire logic                   t2_end,
	// Wake pins
	input  wire logic                   wake_in_a,
	input  wire logic                   wake_in_b,
	input  wire logic                   wake_in_c,
	// Outputs
	output logic [5:0]                  pull_sel_q,
	output logic [2:0]                  wake_level_q,
	output logic                        high_side_switch_out_q,
	output logic                        timer_one_on_q,
	output logic                        cyclic_wake_q
);
	localparam logic [2:0] ON_LOW  = 3'h0;
	localparam logic [2:0] ON_HIGH = 3'h6;
	localparam logic [2:0] HS_T1   = 3'h2;

	logic [7:0]  pull_q, pull_d, flt_q, flt_d, tmr_q, tmr_d, rdata_d;
	logic [2:0]  sync1_q, sync2_q, wk_lvl;
	logic [14:0] tick_q, tick_d;
	logic [14:0] ptk_q, ptk_d;
	logic [14:0] per_ticks, on_ticks;
	logic        on_q, on_d, tend, tick, cyc_sel, hs_d, wake_d;
	wict_pkg::wict_tstate_t st_q, st_d;

	// Period length in 0.1 ms ticks; reserved code gives zero
	function automatic logic [14:0] per_len(input logic [2:0] c);
		unique case (c)
			3'h0: per_len = 15'h0064;
			3'h1: per_len = 15'h00C8;
			3'h2: per_len = 15'h01F4;
			3'h3: per_len = 15'h03E8;
			3'h4: per_len = 15'h07D0;
			3'h5: per_len = 15'h2710;
			3'h6: per_len = 15'h4E20;
			default: per_len = 15'h0000;
		endcase
	endfunction : per_len

	// On-time in 0.1 ms ticks; stop codes give zero
	function automatic logic [14:0] on_len(input logic [2:0] c);
		unique case (c)
			3'h1: on_len = 15'h0001;
			3'h2: on_len = 15'h0003;
			3'h3: on_len = 15'h000A;
			3'h4: on_len = 15'h0064;
			3'h5: on_len = 15'h00C8;
			default: on_len = 15'h0000;
		endcase
	endfunction : on_len

	// Register writes, reads and restart clearing
	always_comb
	begin
		pull_d  = pull_q;
		flt_d   = flt_q;
		tmr_d   = tmr_q;
		rdata_d = rdata_q;
		cyc_sel = flt_q[5] | flt_q[3] | flt_q[1];
		if (req.wr)
		begin
			if (req.addr == `WICT_ADDR_PULL)
				pull_d = req.wdata & `WICT_MASK_CFG; // RQ1 RQ2 RQ3
			if (req.addr == `WICT_ADDR_FILTER)
				flt_d = req.wdata & `WICT_MASK_CFG; // RQ1 RQ7
			if (req.addr == `WICT_ADDR_TIMER)
				tmr_d = req.wdata & `WICT_MASK_TIMER; // RQ1
		end
		if (cyc_sel && restart_mode && switches_cleared)
			tmr_d = `WICT_RESET_VAL; // RQ13
		if (req.rd)
		begin
			unique case (req.addr)
				`WICT_ADDR_PULL:   rdata_d = pull_q;
				`WICT_ADDR_FILTER: rdata_d = flt_q;
				`WICT_ADDR_TIMER:  rdata_d = tmr_q;
				default:           rdata_d = 8'h00;
			endcase
		end
	end

	// Timer one: on-time phase then off phase, repeating each period
	always_comb
	begin
		per_ticks = per_len(tmr_q[`WICT_PER_MSB:`WICT_PER_LSB]); // RQ11
		on_ticks  = on_len(tmr_q[`WICT_ON_MSB:`WICT_ON_LSB]); // RQ9
		tick      = (tick_q == 15'(`WICT_TICK_CYC - 1));
		tick_d    = tick ? 15'h0000 : tick_q + 15'h0001;
		st_d      = st_q;
		ptk_d     = ptk_q;
		tend      = 1'b0;
		if (on_ticks == 15'h0000 || per_ticks == 15'h0000) // RQ10 RQ17
		begin
			st_d   = wict_pkg::WICT_T_STOP;
			ptk_d  = 15'h0000;
			tick_d = 15'h0000;
		end
		else
		begin
			unique case (st_q)
				wict_pkg::WICT_T_STOP:
				begin
					st_d  = wict_pkg::WICT_T_ON; // RQ12
					ptk_d = 15'h0000;
					tick_d = 15'h0000;
				end
				wict_pkg::WICT_T_ON:
					if (tick)
					begin
						ptk_d = ptk_q + 15'h0001;
						if (ptk_q + 15'h0001 >= on_ticks)
						begin
							st_d = wict_pkg::WICT_T_OFF;
							tend = 1'b1;
						end
					end
				wict_pkg::WICT_T_OFF:
					if (tick)
					begin
						ptk_d = ptk_q + 15'h0001;
						if (ptk_q + 15'h0001 >= per_ticks)
						begin
							st_d  = wict_pkg::WICT_T_ON;
							ptk_d = 15'h0000;
						end
					end
				default: st_d = wict_pkg::WICT_T_STOP;
			endcase
		end
		// Flag drops with a stop so it never shows on while a stop code forces the switch low
		on_d = (st_q == wict_pkg::WICT_T_ON) && (st_d != wict_pkg::WICT_T_STOP);
		// A reserved period keeps the output low even with the high stop code
		hs_d = (tmr_q[`WICT_ON_MSB:`WICT_ON_LSB] == ON_HIGH && per_ticks != 15'h0000)
			? 1'b1 : on_d; // RQ10 RQ17
		if (tmr_q[`WICT_ON_MSB:`WICT_ON_LSB] == ON_LOW)
			hs_d = 1'b0;
		if (high_side_switch_mode != HS_T1) // RQ16
			hs_d = 1'b0;
		wake_d = timer_one_wake_enable && tend; // RQ15 RQ14
	end

	// Register stage
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			pull_q  <= `WICT_RESET_VAL; // RQ4
			flt_q   <= `WICT_RESET_VAL; // RQ4
			tmr_q   <= `WICT_RESET_VAL; // RQ4
			rdata_q <= 8'h00;
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
			tick_q  <= 15'h0000;
			ptk_q   <= 15'h0000;
			st_q    <= wict_pkg::WICT_T_STOP;
			on_q    <= 1'b0;
			high_side_switch_out_q <= 1'b0;
			timer_one_on_q <= 1'b0;
			cyclic_wake_q  <= 1'b0;
			pull_sel_q     <= 6'h00;
		end
		else
		begin
			pull_q  <= pull_d;
			flt_q   <= flt_d;
			tmr_q   <= tmr_d;
			rdata_q <= rdata_d;
			sync1_q <= {wake_in_c, wake_in_b, wake_in_a};
			sync2_q <= sync1_q;
			tick_q  <= tick_d;
			ptk_q   <= ptk_d;
			st_q    <= st_d;
			on_q    <= on_d;
			high_side_switch_out_q <= hs_d;
			timer_one_on_q <= on_d;
			cyclic_wake_q  <= wake_d;
			pull_sel_q     <= pull_q[5:0];
		end
	end

	// One qualifier per wake input; sensing runs beside cyclic wake
	for (genvar i = 0; i < 3; i++)
	begin : g_flt
		wict_wake_filter u_flt
		(
			.clk    (clk),
			.nrst   (nrst),
			.sel    (wict_pkg::wict_flt_t'(flt_q[2*i+1 -: 2])),
			.t1_on  (on_q),
			.t1_end (tend),
			.t2_on  (t2_on),
			.t2_end (t2_end),
			.level  (sync2_q[i]),
			.wake_q (wk_lvl[i])
		);
	end

	// Qualified levels registered once more for the port
	always_ff @(posedge clk)
	begin
		if (!nrst)
			wake_level_q <= 3'h0;
		else
			wake_level_q <= wk_lvl;
	end
endmodule : wict_core
`default_nettype wire

// file: core/wict_pkg.sv
package wict_pkg;
	// Pull selection per wake input
	typedef enum logic [1:0] {
		WICT_PULL_NONE = 2'h0,
		WICT_PULL_DOWN = 2'h1,
		WICT_PULL_UP   = 2'h2,
		WICT_PULL_AUTO = 2'h3
	} wict_pull_t;
	// Filter selection per wake input
	typedef enum logic [1:0] {
		WICT_FLT_S16 = 2'h0,
		WICT_FLT_S64 = 2'h1,
		WICT_FLT_CT1 = 2'h2,
		WICT_FLT_CT2 = 2'h3
	} wict_flt_t;
	// Register access port bundle
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} wict_reg_req_t;
	// Timer state
	typedef enum logic [1:0] {
		WICT_T_STOP = 2'b00,
		WICT_T_ON   = 2'b01,
		WICT_T_OFF  = 2'b11
	} wict_tstate_t;
endpackage : wict_pkg

// file: core/wict_wake_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "wict_consts.svh"
// Per-input wake qualifier: static or cyclic sensing
module wict_wake_filter
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// Configuration and timer events
	input  wire wict_pkg::wict_flt_t sel,
	input  wire logic             t1_on,
	input  wire logic             t1_end,
	input  wire logic             t2_on,
	input  wire logic             t2_end,
	// Synchronised input level and result
	input  wire logic             level,
	output logic                  wake_q
);
	logic [11:0] cnt_q;
	logic [11:0] cnt_d;
	logic        last_q;
	logic        last_d;
	logic        wake_d;
	logic [11:0] need;
	logic        cyc;
	logic        win_on;
	logic        win_end;

	// Stability counter; any edge restarts the window
	always_comb
	begin
		cyc     = sel[1];
		win_on  = (sel == wict_pkg::WICT_FLT_CT1) ? t1_on : t2_on;
		win_end = (sel == wict_pkg::WICT_FLT_CT1) ? t1_end : t2_end;
		need    = (sel == wict_pkg::WICT_FLT_S64) ? 12'(`WICT_FLT_LONG_CYC)
		                                          : 12'(`WICT_FLT_SHORT_CYC);
		last_d  = level;
		wake_d  = wake_q;
		cnt_d   = cnt_q;
		if (level != last_q || (cyc && !win_on))
			cnt_d = 12'h000;
		else if (cnt_q < need)
			cnt_d = cnt_q + 12'h001;
		if (!cyc)
		begin
			if (cnt_q >= need) // RQ5
				wake_d = last_q;
		end
		else if (win_end) // RQ6
			wake_d = (cnt_q >= need) ? last_q : wake_q; // RQ18
	end

	// Register stage
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			cnt_q  <= 12'h000;
			last_q <= 1'b0;
			wake_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			last_q <= last_d;
			wake_q <= wake_d;
		end
	end
endmodule : wict_wake_filter
`default_nettype wire

// file: tb/wict_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module wict_core_tb_top;
	// Stimulus
	logic clk = 1'b0, nrst = 1'b0, wk_en = 1'b0, rst_m = 1'b0, sw_clr = 1'b0;
	logic t2_on = 1'b0, t2_end = 1'b0, rd_d = 1'b0;
	logic [2:0] hs_mode = 3'h0, closed = 3'h0;
	logic [7:0] d, exp_q[$];
	logic [6:0] am [4] = '{7'h08, 7'h09, 7'h0C, 7'h0D};
	wict_pkg::wict_reg_req_t req = '0;
	// Results
	wire logic [7:0] rdata_q;
	wire logic [5:0] pull_sel_q;
	wire logic [2:0] lvl, wlev;
	wire logic       hs_out, on_q, cwake;
	int n_fail = 0, total_checks = 0, seed = 83410;
	int n_wake = 0;

	always #20 clk = ~clk;
	wict_core uut (.clk(clk), .nrst(nrst), .req(req), .rdata_q(rdata_q),
		.timer_one_wake_enable(wk_en), .high_side_switch_mode(hs_mode),
		.restart_mode(rst_m), .switches_cleared(sw_clr), .t2_on(t2_on), .t2_end(t2_end),
		.wake_in_a(lvl[0]), .wake_in_b(lvl[1]), .wake_in_c(lvl[2]), .pull_sel_q(pull_sel_q),
		.wake_level_q(wlev), .high_side_switch_out_q(hs_out), .timer_one_on_q(on_q),
		.cyclic_wake_q(cwake));
	for (genvar i = 0; i < 3; i++)
	begin : g_pin
		wict_switch_model sw (.clk(clk), .pull(pull_sel_q[2*i+:2]), .closed(closed[i]),
			.level(lvl[i]));
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One access; a read notes its expected data for the watcher
	task automatic acc(input logic wr, input logic [6:0] a, input logic [7:0] v);
		@(negedge clk);
		req = '{wr: wr, rd: !wr, addr: a, wdata: v};
		if (!wr)
			exp_q.push_back(v);
		@(negedge clk);
		req = '0;
	endtask : acc
	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test
	// Bounded wait for the timer output
	task automatic wait_on(input logic v);
		for (int k = 0; k < 8 && on_q !== v; k++)
			@(negedge clk);
		if (on_q !== v)
		begin
			n_fail++;
			finish_test();
		end
	endtask : wait_on

	// Read data is settled by the falling edge after the read edge
	always @(posedge clk) rd_d <= req.rd;
	// Wake pulses seen; one is expected per finished on-time while enabled
	always @(negedge clk)
		if (cwake === 1'b1)
			n_wake++;
	always @(negedge clk)
		if (rd_d && exp_q.size() > 0)
			chk(rdata_q, exp_q.pop_front());

	initial
	begin
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		foreach (am[i]) acc(1'b0, am[i], 8'h00);
		// Random write and read-back; reserved bits must drop
		repeat (6)
		begin
			d = 8'($random(seed));
			acc(1'b1, 7'h08, d);
			acc(1'b0, 7'h08, d & 8'h3F);
			chk({2'h0, pull_sel_q}, d & 8'h3F);
			chk(8'(hs_out), 8'h00);
			acc(1'b1, 7'h09, d);
			acc(1'b0, 7'h09, d & 8'h3F);
			acc(1'b1, 7'h0C, d);
			acc(1'b0, 7'h0C, d & 8'h77);
		end
		// Static filters: pull-ups, switches released after a settled low
		closed = 3'h7;
		acc(1'b1, 7'h08, 8'h2A);
		acc(1'b1, 7'h09, 8'h00);
		acc(1'b1, 7'h0C, 8'h00);
		repeat (500) @(negedge clk);
		closed = 3'h0;
		repeat (300) @(negedge clk);
		chk(8'(wlev), 8'h00);
		repeat (200) @(negedge clk);
		chk(8'(wlev), 8'h07);
		acc(1'b1, 7'h09, 8'h01);
		closed = 3'h1;
		repeat (1000) @(negedge clk);
		chk(8'(wlev), 8'h07);
		repeat (700) @(negedge clk);
		chk(8'(wlev), 8'h06);
		// Cyclic sensing of b on timer one, routed to the switch
		hs_mode = 3'b010;
		wk_en = 1'b1;
		closed = 3'h3;
		acc(1'b1, 7'h09, 8'h09);
		repeat (600) @(negedge clk);
		chk(8'(wlev), 8'h06);
		acc(1'b1, 7'h0C, 8'h10);
		wait_on(1'b1);
		chk(8'(hs_out), 8'h01);
		repeat (2450) @(negedge clk);
		chk(8'(on_q), 8'h01);
		repeat (100) @(negedge clk);
		chk(8'(on_q), 8'h00);
		chk(8'(wlev), 8'h04);
		chk(8'(n_wake), 8'h01);
		// Timer two window for c
		closed = 3'h7;
		acc(1'b1, 7'h09, 8'h39);
		t2_on = 1'b1;
		repeat (500) @(negedge clk);
		chk(8'(wlev), 8'h04);
		t2_end = 1'b1;
		@(negedge clk);
		t2_end = 1'b0;
		t2_on = 1'b0;
		repeat (4) @(negedge clk);
		chk(8'(wlev), 8'h00);
		// Stopped codes, reserved ones included
		wk_en = 1'b0;
		foreach (am[i])
		begin
			d = i == 0 ? 8'h60 : i == 1 ? 8'h00 : i == 2 ? 8'h70 : 8'h17;
			acc(1'b1, 7'h0C, d);
			repeat (4) @(negedge clk);
			chk(8'(hs_out), i == 0 ? 8'h01 : 8'h00);
			chk(8'(on_q), 8'h00);
		end
		// Restart clear of a running timer under cyclic sensing
		acc(1'b1, 7'h0C, 8'h15);
		wait_on(1'b1);
		rst_m = 1'b1;
		sw_clr = 1'b1;
		repeat (2) @(negedge clk);
		rst_m = 1'b0;
		sw_clr = 1'b0;
		acc(1'b0, 7'h0C, 8'h00);
		chk(8'(on_q), 8'h00);
		repeat (2) @(negedge clk);
		finish_test();
	end
endmodule : wict_core_tb_top
`default_nettype wire

// file: tb/wict_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module wict_monitor
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       nrst,
	// Register port
	input wire wict_pkg::wict_reg_req_t req,
	input wire logic [7:0] rdata_q,
	// Context and results
	input wire logic       timer_one_wake_enable,
	input wire logic [2:0] high_side_switch_mode,
	input wire logic       restart_mode,
	input wire logic [5:0] pull_sel_q,
	input wire logic       high_side_switch_out_q,
	input wire logic       timer_one_on_q,
	input wire logic       cyclic_wake_q
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// Timer writes count only outside restart, since a restart clear wins
	wire logic       wr_t   = req.wr && req.addr == 7'h0C && !restart_mode;
	wire logic [2:0] on_c   = req.wdata[6:4];
	wire logic       stop_c = on_c inside {3'h0, 3'h6, 3'h7} || req.wdata[2:0] == 3'h7;
	wire logic       mapped = req.addr inside {7'h08, 7'h09, 7'h0C};
	wire logic       hs_t1  = high_side_switch_mode == 3'b010;

	pull_copy_a: assert property (req.wr && req.addr == 7'h08 |->
		##2 pull_sel_q == $past(req.wdata[5:0], 2)) else $error("pull copy wrong");
	timer_res_a: assert property (req.rd && req.addr == 7'h0C |->
		##1 {rdata_q[7], rdata_q[3]} == 2'b00) else $error("timer reserved bit set");
	unmapped_rd_a: assert property (req.rd && !mapped |=> rdata_q == 8'h00)
		else $error("unmapped read not zero");
	timer_start_a: assert property (wr_t && !stop_c |-> ##[1:3] timer_one_on_q)
		else $error("timer did not start");
	timer_stop_a: assert property (wr_t && stop_c |-> ##3 !timer_one_on_q)
		else $error("timer still running");
	switch_follow_a: assert property (hs_t1 && $past(hs_t1) && timer_one_on_q |->
		high_side_switch_out_q) else $error("switch not following timer");
	wake_pulse_a: assert property ($fell(timer_one_on_q) && $past(timer_one_wake_enable, 2)
		|-> $past(cyclic_wake_q)) else $error("no wake");
	wake_off_a: assert property (!timer_one_wake_enable && $past(!timer_one_wake_enable)
		|-> !cyclic_wake_q) else $error("wake while disabled");

	// Main scenarios reached
	cover property ($rose(timer_one_on_q));
	cover property (cyclic_wake_q);
	cover property (req.rd && !mapped);
endmodule : wict_monitor
bind wict_core wict_monitor mon (.clk(clk), .nrst(nrst), .req(req), .rdata_q(rdata_q),
	.timer_one_wake_enable(timer_one_wake_enable),
	.high_side_switch_mode(high_side_switch_mode), .restart_mode(restart_mode),
	.pull_sel_q(pull_sel_q), .high_side_switch_out_q(high_side_switch_out_q),
	.timer_one_on_q(timer_one_on_q), .cyclic_wake_q(cyclic_wake_q));
`default_nettype wire

// file: tb/wict_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
// Wake pin with a switch to ground and the pull that the block selects
module wict_switch_model
(
	// Clock
	input wire logic       clk,
	// Pull code and switch state
	input wire logic [1:0] pull,
	input wire logic       closed,
	// Pin level
	output var logic       level
);
	initial level = 1'b0;
	// An open pin without pull floats, so it toggles instead of keeping a value
	always @(posedge clk)
	begin
		if (closed)
			level <= 1'b0;
		else if (pull == 2'h2)
			level <= 1'b1;
		else if (pull == 2'h1)
			level <= 1'b0;
		else if (pull == 2'h0)
			level <= ~level;
	end
endmodule : wict_switch_model
`default_nettype wire
